/* File: core/ldx_diag_lane.sv */
/*
  One bit lane of the debug output port: picks a bit of a diagnostic word and
  optionally inverts it.
  Assumes word, select and invert come from the same clock domain.
*/
module ldx_diag_lane (
  // Word and controls
  input wire logic [ldx_pkg::WORD_W-1:0] word,
  input wire logic [ldx_pkg::LANE_SEL_W-1:0] bit_sel,
  input wire logic invert,
  // Selected bit
  output logic bit_out
);

  always_comb begin
    bit_out = word[bit_sel] ^ invert;
  end

endmodule

/* File: core/ldx_pkg.sv */
/*
  Constants, register map and state types for the link diagnostic mux and
  exchange-memory error block.
  Assumes a single system clock and an AXI4-Lite master that holds each
  payload until its handshake.
*/
package ldx_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_CTRL = 32'h4000_0200;
  localparam logic [31:0] ADDR_XMEM_BASE = 32'h4000_0208;
  localparam logic [31:0] ADDR_WORD_SEL = 32'h4000_020C;
  localparam logic [31:0] ADDR_BIT_SEL = 32'h4000_0210;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000_0214;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_0218;

  // Control register fields
  localparam int CTRL_FLAG_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int CTRL_MASK_BIT = 2;
  localparam int CTRL_OVR_BIT = 3;
  localparam logic CTRL_MASK_RST = 1'b1;
  localparam logic CTRL_OVR_RST = 1'b0;

  // Exchange memory base field
  localparam int XBASE_LSB = 10;
  localparam int XBASE_W = 7;
  localparam logic [XBASE_W-1:0] XBASE_RST = 7'h00;

  // Word select register: enable at 8k+7, select at 8k+5:8k
  localparam int SEL_STRIDE = 8;
  localparam int SEL_EN_POS = 7;
  localparam int SEL_W = 6;
  localparam logic [31:0] WORD_SEL_RW_MASK = 32'hBFBF_BFBF;
  localparam logic [31:0] WORD_SEL_RST = 32'h0000_0000;

  // Bit select register: bit index at 4n+2:4n, invert at 4n+3
  localparam int LANE_STRIDE = 4;
  localparam int LANE_INV_POS = 3;
  localparam int LANE_SEL_W = 3;
  localparam logic [31:0] BIT_SEL_RST = 32'h0000_0000;

  // Interrupt status/mask: bit 0 is the access error event
  localparam int IRQ_ERR_BIT = 0;
  localparam logic IRQ_STATUS_RST = 1'b0;
  localparam logic IRQ_MASK_RST = 1'b0;

  // Diagnostic sizes
  localparam int WORD_W = 8;
  localparam int NUM_WORDS = 8;
  localparam int NUM_DIRECT_WORDS = 4;
  localparam int NUM_GROUPS = 64;
  localparam int PAGE_W = 3;
  localparam int NUM_PAGES = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    LDX_WR_COLLECT = 2'b01,
    LDX_WR_RESP = 2'b10
  } ldx_wr_state_t;

  typedef enum logic [1:0] {
    LDX_RD_IDLE = 2'b01,
    LDX_RD_DATA = 2'b10
  } ldx_rd_state_t;

endpackage

/* File: core/ldx_top.sv */
/*
  Top of the link diagnostic mux and exchange-memory error block: AXI4-Lite
  register slave, access error flag with interrupts, registered debug port.
  Assumes link controller inputs are on CLK; CE must be high during bus traffic.
*/
module ldx_top (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // AXI4-Lite write address
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  // AXI4-Lite write data
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  // AXI4-Lite write response
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  // AXI4-Lite read address
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  // AXI4-Lite read data
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  // Exchange memory accesses from the link controller
  input wire logic XMEM_ACCESS,
  input wire logic [ldx_pkg::PAGE_W-1:0] XMEM_ACCESS_PAGE,
  input wire logic [ldx_pkg::NUM_PAGES-1:0] XMEM_PAGE_MAPPING,
  // Internal diagnostic sources
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD0,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD1,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD2,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD3,
  input wire logic [ldx_pkg::NUM_GROUPS*ldx_pkg::WORD_W-1:0] DIAG_GROUPS,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_OVR_DATA,
  // Outputs
  output logic [ldx_pkg::WORD_W-1:0] DEBUG_OUTPUT_PORT,
  output logic LINK_ERROR_INTERRUPT,
  output logic IRQ,
  output logic [ldx_pkg::NUM_PAGES-1:0] XMEM_BASE_FIELD_OUT
);

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = data[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Known register address
  function automatic logic addr_hit(input logic [31:0] a);
    logic [31:0] w;
    w = {a[31:2], 2'b00};
    return (w == ldx_pkg::ADDR_CTRL) || (w == ldx_pkg::ADDR_XMEM_BASE) ||
           (w == ldx_pkg::ADDR_WORD_SEL) || (w == ldx_pkg::ADDR_BIT_SEL) ||
           (w == ldx_pkg::ADDR_IRQ_STATUS) || (w == ldx_pkg::ADDR_IRQ_MASK);
  endfunction

  // Pick one signal group of the internal diagnostic bus
  function automatic logic [ldx_pkg::WORD_W-1:0] group_pick(
      input logic [ldx_pkg::NUM_GROUPS*ldx_pkg::WORD_W-1:0] g,
      input logic [ldx_pkg::SEL_W-1:0] s);
    return g[{s, 3'b000} +: ldx_pkg::WORD_W];
  endfunction

  // Write channel state
  ldx_pkg::ldx_wr_state_t wr_state, next_wr_state;
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [31:0] awaddr_q, next_awaddr_q;
  logic [31:0] wdata_q, next_wdata_q;
  logic [3:0] wstrb_q, next_wstrb_q;
  logic next_awready, next_wready, next_bvalid;
  logic [1:0] next_bresp;
  logic wr_fire;
  logic [31:0] wr_word;

  // Read channel state
  ldx_pkg::ldx_rd_state_t rd_state, next_rd_state;
  logic next_arready, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic rd_fire;
  logic [31:0] rd_word;

  // Register state
  logic err_flag, next_err_flag;
  logic err_mask, next_err_mask;
  logic ovr, next_ovr;
  logic [ldx_pkg::XBASE_W-1:0] xbase, next_xbase;
  logic [31:0] word_sel, next_word_sel;
  logic [31:0] bit_sel, next_bit_sel;
  logic irq_status, next_irq_status;
  logic irq_mask, next_irq_mask;
  logic next_link_irq, next_irq;
  logic err_evt, clr_wr, stat_rd_clr;

  // Diagnostic path
  logic [ldx_pkg::WORD_W-1:0] words [ldx_pkg::NUM_WORDS];
  logic [ldx_pkg::WORD_W-1:0] lane_bits;
  logic [ldx_pkg::WORD_W-1:0] next_port;

  // Write channel: address and data taken in either order
  always_comb begin
    next_wr_state = wr_state;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_awaddr_q = awaddr_q;
    next_wdata_q = wdata_q;
    next_wstrb_q = wstrb_q;
    next_awready = 1'b0;
    next_wready = 1'b0;
    next_bvalid = S_AXI_BVALID;
    next_bresp = S_AXI_BRESP;
    wr_fire = 1'b0;
    case (wr_state)
      ldx_pkg::LDX_WR_COLLECT: begin
        next_awready = S_AXI_AWVALID && !aw_got && !S_AXI_AWREADY;
        next_wready = S_AXI_WVALID && !w_got && !S_AXI_WREADY;
        if (S_AXI_AWREADY && S_AXI_AWVALID) begin
          next_aw_got = 1'b1;
          next_awaddr_q = S_AXI_AWADDR;
        end
        if (S_AXI_WREADY && S_AXI_WVALID) begin
          next_w_got = 1'b1;
          next_wdata_q = S_AXI_WDATA;
          next_wstrb_q = S_AXI_WSTRB;
        end
        if (aw_got && w_got) begin
          wr_fire = 1'b1;
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = addr_hit(awaddr_q) ? ldx_pkg::RESP_OKAY : ldx_pkg::RESP_SLVERR;
          next_wr_state = ldx_pkg::LDX_WR_RESP;
        end
      end
      ldx_pkg::LDX_WR_RESP: begin
        if (S_AXI_BREADY) begin
          next_bvalid = 1'b0;
          next_wr_state = ldx_pkg::LDX_WR_COLLECT;
        end
      end
      default: begin
        next_wr_state = ldx_pkg::LDX_WR_COLLECT;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      wr_state <= ldx_pkg::LDX_WR_COLLECT;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= 2'h0;
    end else if (CE) begin
      wr_state <= next_wr_state;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      awaddr_q <= next_awaddr_q;
      wdata_q <= next_wdata_q;
      wstrb_q <= next_wstrb_q;
      S_AXI_AWREADY <= next_awready;
      S_AXI_WREADY <= next_wready;
      S_AXI_BVALID <= next_bvalid;
      S_AXI_BRESP <= next_bresp;
    end
  end

  // Read channel with register readback
  always_comb begin
    next_rd_state = rd_state;
    next_arready = 1'b0;
    next_rvalid = S_AXI_RVALID;
    next_rdata = S_AXI_RDATA;
    next_rresp = S_AXI_RRESP;
    rd_fire = 1'b0;
    rd_word = 32'h0000_0000;
    case ({S_AXI_ARADDR[31:2], 2'b00})
      ldx_pkg::ADDR_CTRL: begin
        rd_word[ldx_pkg::CTRL_FLAG_BIT] = err_flag;
        rd_word[ldx_pkg::CTRL_MASK_BIT] = err_mask;
        rd_word[ldx_pkg::CTRL_OVR_BIT] = ovr; // clear field reads zero
      end
      ldx_pkg::ADDR_XMEM_BASE: rd_word[ldx_pkg::XBASE_LSB +: ldx_pkg::XBASE_W] = xbase;
      ldx_pkg::ADDR_WORD_SEL: rd_word = word_sel;
      ldx_pkg::ADDR_BIT_SEL: rd_word = bit_sel;
      ldx_pkg::ADDR_IRQ_STATUS: rd_word[ldx_pkg::IRQ_ERR_BIT] = irq_status;
      ldx_pkg::ADDR_IRQ_MASK: rd_word[ldx_pkg::IRQ_ERR_BIT] = irq_mask;
      default: rd_word = 32'h0000_0000;
    endcase
    case (rd_state)
      ldx_pkg::LDX_RD_IDLE: begin
        next_arready = S_AXI_ARVALID && !S_AXI_ARREADY;
        if (S_AXI_ARREADY && S_AXI_ARVALID) begin
          rd_fire = 1'b1;
          next_rdata = rd_word;
          next_rresp = addr_hit(S_AXI_ARADDR) ? ldx_pkg::RESP_OKAY : ldx_pkg::RESP_SLVERR;
          next_rvalid = 1'b1;
          next_rd_state = ldx_pkg::LDX_RD_DATA;
        end
      end
      ldx_pkg::LDX_RD_DATA: begin
        if (S_AXI_RREADY) begin
          next_rvalid = 1'b0;
          next_rd_state = ldx_pkg::LDX_RD_IDLE;
        end
      end
      default: begin
        next_rd_state = ldx_pkg::LDX_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_state <= ldx_pkg::LDX_RD_IDLE;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= 2'h0;
    end else if (CE) begin
      rd_state <= next_rd_state;
      S_AXI_ARREADY <= next_arready;
      S_AXI_RVALID <= next_rvalid;
      S_AXI_RDATA <= next_rdata;
      S_AXI_RRESP <= next_rresp;
    end
  end

  // Register updates, error flag and interrupts
  always_comb begin
    wr_word = 32'h0000_0000;
    err_evt = XMEM_ACCESS && !XMEM_PAGE_MAPPING[XMEM_ACCESS_PAGE];
    clr_wr = 1'b0;
    stat_rd_clr = rd_fire && ({S_AXI_ARADDR[31:2], 2'b00} == ldx_pkg::ADDR_IRQ_STATUS);
    next_err_mask = err_mask;
    next_ovr = ovr;
    next_xbase = xbase;
    next_word_sel = word_sel;
    next_bit_sel = bit_sel;
    next_irq_mask = irq_mask;
    if (wr_fire) begin
      case ({awaddr_q[31:2], 2'b00})
        ldx_pkg::ADDR_CTRL: begin
          wr_word = wmerge(32'h0000_0000, wdata_q, wstrb_q);
          clr_wr = wstrb_q[0] && wr_word[ldx_pkg::CTRL_CLEAR_BIT];
          if (wstrb_q[0]) begin
            next_err_mask = wr_word[ldx_pkg::CTRL_MASK_BIT];
            next_ovr = wr_word[ldx_pkg::CTRL_OVR_BIT];
          end
        end
        ldx_pkg::ADDR_XMEM_BASE: begin
          wr_word = wmerge({15'h0000, xbase, 10'h000}, wdata_q, wstrb_q);
          next_xbase = wr_word[ldx_pkg::XBASE_LSB +: ldx_pkg::XBASE_W];
        end
        ldx_pkg::ADDR_WORD_SEL: begin
          wr_word = wmerge(word_sel, wdata_q, wstrb_q);
          next_word_sel = wr_word & ldx_pkg::WORD_SEL_RW_MASK;
        end
        ldx_pkg::ADDR_BIT_SEL: begin
          next_bit_sel = wmerge(bit_sel, wdata_q, wstrb_q);
        end
        ldx_pkg::ADDR_IRQ_MASK: begin
          if (wstrb_q[0]) begin
            next_irq_mask = wdata_q[ldx_pkg::IRQ_ERR_BIT];
          end
        end
        default: wr_word = 32'h0000_0000;
      endcase
    end
    // A new error in the clearing cycle keeps the flag set
    next_err_flag = err_evt || (err_flag && !clr_wr);
    next_irq_status = err_evt || (irq_status && !stat_rd_clr);
    next_link_irq = next_err_flag && next_err_mask;
    next_irq = next_irq_status && next_irq_mask;
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      err_flag <= 1'b0;
      err_mask <= ldx_pkg::CTRL_MASK_RST;
      ovr <= ldx_pkg::CTRL_OVR_RST;
      xbase <= ldx_pkg::XBASE_RST;
      word_sel <= ldx_pkg::WORD_SEL_RST;
      bit_sel <= ldx_pkg::BIT_SEL_RST;
      irq_status <= ldx_pkg::IRQ_STATUS_RST;
      irq_mask <= ldx_pkg::IRQ_MASK_RST;
      LINK_ERROR_INTERRUPT <= 1'b0;
      IRQ <= 1'b0;
    end else if (CE) begin
      err_flag <= next_err_flag;
      err_mask <= next_err_mask;
      ovr <= next_ovr;
      xbase <= next_xbase;
      word_sel <= next_word_sel;
      bit_sel <= next_bit_sel;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      LINK_ERROR_INTERRUPT <= next_link_irq;
      IRQ <= next_irq;
    end
  end

  // Diagnostic words: four direct, four selected from the group bus
  always_comb begin
    words[0] = DIAG_WORD0;
    words[1] = DIAG_WORD1;
    words[2] = DIAG_WORD2;
    words[3] = DIAG_WORD3;
    for (int k = 0; k < ldx_pkg::NUM_WORDS - ldx_pkg::NUM_DIRECT_WORDS; k++) begin
      if (word_sel[ldx_pkg::SEL_STRIDE*k + ldx_pkg::SEL_EN_POS]) begin
        words[ldx_pkg::NUM_DIRECT_WORDS + k] =
          group_pick(DIAG_GROUPS, word_sel[ldx_pkg::SEL_STRIDE*k +: ldx_pkg::SEL_W]);
      end else begin
        words[ldx_pkg::NUM_DIRECT_WORDS + k] = 8'h00;
      end
    end
  end

  // One lane per port bit
  for (genvar n = 0; n < ldx_pkg::NUM_WORDS; n++) begin : g_lane
    ldx_diag_lane u_lane (
      .word(words[n]),
      .bit_sel(bit_sel[ldx_pkg::LANE_STRIDE*n +: ldx_pkg::LANE_SEL_W]),
      .invert(bit_sel[ldx_pkg::LANE_STRIDE*n + ldx_pkg::LANE_INV_POS]),
      .bit_out(lane_bits[n])
    );
  end

  always_comb begin
    next_port = ovr ? DIAG_OVR_DATA : lane_bits;
  end

  // Registered port and base field
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      DEBUG_OUTPUT_PORT <= 8'h00;
      XMEM_BASE_FIELD_OUT <= 8'h00;
    end else if (CE) begin
      DEBUG_OUTPUT_PORT <= next_port;
      XMEM_BASE_FIELD_OUT <= {1'b0, next_xbase};
    end
  end

endmodule

/* File: tb/ldx_observer.sv */
/*
  Observer at the debug pins: latches what the pins show mid-cycle.
  Assumes the pins are stable away from the rising clock edge.
*/
module ldx_observer (
  // Clock
  input wire logic clk,
  // Watched pins
  input wire logic [7:0] pins,
  // Last value seen
  output logic [7:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(negedge clk) begin
    seen <= pins;
  end
endmodule

/* File: tb/ldx_props.sv */
/*
  Checker for the link diagnostic block: mirrors register writes, checks
  debug port, base field, error interrupt and write responses.
  Assumes it is bound to ldx_top and sees only its ports.
*/
module ldx_props (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // Write channels
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  // Link side
  input wire logic XMEM_ACCESS,
  input wire logic [ldx_pkg::PAGE_W-1:0] XMEM_ACCESS_PAGE,
  input wire logic [ldx_pkg::NUM_PAGES-1:0] XMEM_PAGE_MAPPING,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD0,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD1,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD2,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_WORD3,
  input wire logic [ldx_pkg::NUM_GROUPS*ldx_pkg::WORD_W-1:0] DIAG_GROUPS,
  input wire logic [ldx_pkg::WORD_W-1:0] DIAG_OVR_DATA,
  // Outputs
  input wire logic [ldx_pkg::WORD_W-1:0] DEBUG_OUTPUT_PORT,
  input wire logic LINK_ERROR_INTERRUPT,
  input wire logic [ldx_pkg::NUM_PAGES-1:0] XMEM_BASE_FIELD_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] wa, wd, ws, bs;
  logic [3:0] wb;
  logic ga, gw, ovr, msk, flg, okw, bad, go;
  logic [6:0] base;
  logic [7:0][7:0] w;
  logic [7:0] ex;
  logic [29:0] ix;
  assign bad = XMEM_ACCESS && !XMEM_PAGE_MAPPING[XMEM_ACCESS_PAGE];
  assign go = ga && gw && !S_AXI_BVALID;
  assign ix = wa[31:2];
  // Expected mux output from mirrored fields
  always_comb begin
    w[3:0] = {DIAG_WORD3, DIAG_WORD2, DIAG_WORD1, DIAG_WORD0};
    for (int n = 4; n < 8; n++) begin
      w[n] = ws[8*n-25] ? DIAG_GROUPS[{ws[8*n-32 +: 6], 3'b000} +: 8] : 8'h00;
    end
    for (int n = 0; n < 8; n++) begin
      ex[n] = ovr ? DIAG_OVR_DATA[n] : w[n][bs[4*n +: 3]] ^ bs[4*n+3];
    end
  end
  // Register mirror, written when the slave executes a write
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ga <= 1'b0;
      gw <= 1'b0;
      ovr <= 1'b0;
      msk <= 1'b1;
      flg <= 1'b0;
      okw <= 1'b0;
      base <= 7'h00;
      ws <= 32'h0;
      bs <= 32'h0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        ga <= 1'b1;
        wa <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        gw <= 1'b1;
        wd <= S_AXI_WDATA;
        wb <= S_AXI_WSTRB;
      end
      if (bad) begin
        flg <= 1'b1;
      end
      if (go) begin
        ga <= 1'b0;
        gw <= 1'b0;
        okw <= ix inside {ldx_pkg::ADDR_CTRL[31:2], ldx_pkg::ADDR_XMEM_BASE[31:2],
          ldx_pkg::ADDR_WORD_SEL[31:2], ldx_pkg::ADDR_BIT_SEL[31:2],
          ldx_pkg::ADDR_IRQ_STATUS[31:2], ldx_pkg::ADDR_IRQ_MASK[31:2]};
        if (ix == ldx_pkg::ADDR_CTRL[31:2] && wb[0]) begin
          ovr <= wd[ldx_pkg::CTRL_OVR_BIT];
          msk <= wd[ldx_pkg::CTRL_MASK_BIT];
          if (wd[ldx_pkg::CTRL_CLEAR_BIT] && !bad) begin
            flg <= 1'b0;
          end
        end
        if (ix == ldx_pkg::ADDR_XMEM_BASE[31:2] && wb[1]) begin
          base[5:0] <= wd[15:10];
        end
        if (ix == ldx_pkg::ADDR_XMEM_BASE[31:2] && wb[2]) begin
          base[6] <= wd[16];
        end
        for (int i = 0; i < 4; i++) begin
          if (wb[i] && ix == ldx_pkg::ADDR_WORD_SEL[31:2]) begin
            ws[8*i +: 8] <= wd[8*i +: 8] & ldx_pkg::WORD_SEL_RW_MASK[8*i +: 8];
          end
          if (wb[i] && ix == ldx_pkg::ADDR_BIT_SEL[31:2]) begin
            bs[8*i +: 8] <= wd[8*i +: 8];
          end
        end
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  port_mux_a: assert property (CE && $past(RESETN) |=> DEBUG_OUTPUT_PORT == $past(ex))
    else $error("debug port differs from selected bits");
  base_field_a: assert property (XMEM_BASE_FIELD_OUT == {1'b0, base})
    else $error("base field output wrong");
  err_irq_a: assert property (LINK_ERROR_INTERRUPT == (flg && msk))
    else $error("link error interrupt wrong");
  err_rise_a: assert property (!LINK_ERROR_INTERRUPT && !bad |=> !LINK_ERROR_INTERRUPT || $rose(S_AXI_BVALID))
    else $error("interrupt rose without cause");
  wr_resp_a: assert property (CE && go |=> S_AXI_BVALID)
    else $error("write response late");
  resp_code_a: assert property (S_AXI_BVALID |-> S_AXI_BRESP == (okw ? ldx_pkg::RESP_OKAY : ldx_pkg::RESP_SLVERR))
    else $error("write response code wrong");
  resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  ready_pulse_a: assert property (CE && S_AXI_AWREADY |=> !S_AXI_AWREADY)
    else $error("address ready not a pulse");
  cover property (bad && !LINK_ERROR_INTERRUPT);
  cover property ($fell(LINK_ERROR_INTERRUPT));
  cover property (S_AXI_BVALID && !okw);
endmodule

bind ldx_top ldx_props ldx_props_inst (
  .CLK, .RESETN, .CE, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR, .S_AXI_WVALID,
  .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
  .XMEM_ACCESS, .XMEM_ACCESS_PAGE, .XMEM_PAGE_MAPPING, .DIAG_WORD0, .DIAG_WORD1,
  .DIAG_WORD2, .DIAG_WORD3, .DIAG_GROUPS, .DIAG_OVR_DATA, .DEBUG_OUTPUT_PORT,
  .LINK_ERROR_INTERRUPT, .XMEM_BASE_FIELD_OUT
);

/* File: tb/testbench.sv */
/*
  Self-checking bench for ldx_top: register bus, error flag, interrupts
  and debug port mux.
  Assumes ldx_props is bound and ldx_observer watches the pins.
*/
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RESETN = 1'b0, CE = 1'b1, S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0;
  logic S_AXI_BREADY = 1'b0, S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0, XMEM_ACCESS = 1'b0;
  logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
  logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0, XMEM_ACCESS_PAGE = 3'h0;
  logic [3:0] S_AXI_WSTRB = 4'hF;
  logic [7:0] XMEM_PAGE_MAPPING = 8'hFF, DIAG_WORD0 = 8'h5A, DIAG_WORD1 = 8'h3C;
  logic [7:0] DIAG_WORD2 = 8'h96, DIAG_WORD3 = 8'hE1, DIAG_OVR_DATA = 8'hC3;
  logic [511:0] DIAG_GROUPS;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic LINK_ERROR_INTERRUPT, IRQ;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [31:0] S_AXI_RDATA;
  logic [7:0] DEBUG_OUTPUT_PORT, XMEM_BASE_FIELD_OUT, seen;
  int err_total = 0;
  int total_checks = 0;
  ldx_top ldx_top_inst (.CLK, .RESETN, .CE, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_AWADDR,
    .S_AXI_AWPROT, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR,
    .S_AXI_ARPROT, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_RRESP, .XMEM_ACCESS,
    .XMEM_ACCESS_PAGE, .XMEM_PAGE_MAPPING, .DIAG_WORD0, .DIAG_WORD1, .DIAG_WORD2,
    .DIAG_WORD3, .DIAG_GROUPS, .DIAG_OVR_DATA, .DEBUG_OUTPUT_PORT, .LINK_ERROR_INTERRUPT,
    .IRQ, .XMEM_BASE_FIELD_OUT);
  ldx_observer ldx_observer_inst (.clk(CLK), .pins(DEBUG_OUTPUT_PORT), .seen(seen));
  always #10 CLK = ~CLK;
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tmo(input int i);
    if (i >= 100) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] er = ldx_pkg::RESP_OKAY);
    logic pa, pw;
    int i;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= s;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    for (i = 0; i < 50 && (pa || pw); i++) begin
      @(negedge CLK);
      pa = pa && !S_AXI_AWREADY;
      pw = pw && !S_AXI_WREADY;
      @(posedge CLK);
      if (!pa) S_AXI_AWVALID <= 1'b0;
      if (!pw) S_AXI_WVALID <= 1'b0;
    end
    for (; i < 100; i++) begin
      @(negedge CLK);
      if (S_AXI_BVALID) break;
    end
    tmo(i);
    `CHK(S_AXI_BRESP, er)
    @(posedge CLK);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                    input logic [1:0] er = ldx_pkg::RESP_OKAY);
    int i;
    @(posedge CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge CLK);
      if (S_AXI_ARREADY) break;
    end
    @(posedge CLK);
    S_AXI_ARVALID <= 1'b0;
    for (; i < 100; i++) begin
      @(negedge CLK);
      if (S_AXI_RVALID) break;
    end
    tmo(i);
    `CHK(S_AXI_RDATA, ed)
    `CHK(S_AXI_RRESP, er)
    @(posedge CLK);
    S_AXI_RREADY <= 1'b0;
  endtask
  task automatic acc(input logic [2:0] p, input logic el, input logic ei);
    @(posedge CLK);
    XMEM_ACCESS <= 1'b1;
    XMEM_ACCESS_PAGE <= p;
    @(posedge CLK);
    XMEM_ACCESS <= 1'b0;
    @(negedge CLK);
    `CHK(LINK_ERROR_INTERRUPT, el)
    `CHK(IRQ, ei)
    @(posedge CLK);
  endtask
  function automatic logic [7:0] port_exp(input logic [31:0] ws, input logic [31:0] bs);
    logic [7:0][7:0] w;
    logic [7:0] r;
    w[3:0] = {DIAG_WORD3, DIAG_WORD2, DIAG_WORD1, DIAG_WORD0};
    for (int n = 4; n < 8; n++) begin
      w[n] = ws[8*n-25] ? DIAG_GROUPS[8*ws[8*n-32 +: 6] +: 8] : 8'h00;
    end
    for (int n = 0; n < 8; n++) begin
      r[n] = w[n][bs[4*n +: 3]] ^ bs[4*n+3];
    end
    return r;
  endfunction
  task automatic t_regs();
    rd(ldx_pkg::ADDR_CTRL, 32'h0000_0004);
    rd(ldx_pkg::ADDR_XMEM_BASE, 32'h0);
    rd(ldx_pkg::ADDR_WORD_SEL, 32'h0);
    rd(ldx_pkg::ADDR_BIT_SEL, 32'h0);
    rd(ldx_pkg::ADDR_IRQ_MASK, 32'h0);
    `CHK(LINK_ERROR_INTERRUPT, 1'b0)
    $display("t_regs done");
  endtask
  task automatic t_base();
    wr(ldx_pkg::ADDR_XMEM_BASE, 32'hFFFF_FFFF);
    rd(ldx_pkg::ADDR_XMEM_BASE, 32'h0001_FC00);
    `CHK(XMEM_BASE_FIELD_OUT, 8'h7F)
    wr(ldx_pkg::ADDR_XMEM_BASE, 32'h0, 4'h2);
    rd(ldx_pkg::ADDR_XMEM_BASE, 32'h0001_0000);
    wr(32'h4000_0204, 32'hFFFF_FFFF, 4'hF, ldx_pkg::RESP_SLVERR);
    rd(32'h4000_0204, 32'h0, ldx_pkg::RESP_SLVERR);
    $display("t_base done");
  endtask
  task automatic t_err();
    XMEM_PAGE_MAPPING <= 8'hFE;
    acc(3'h1, 1'b0, 1'b0);
    acc(3'h0, 1'b1, 1'b0);
    rd(ldx_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(ldx_pkg::ADDR_CTRL, 32'h0000_0004);
    rd(ldx_pkg::ADDR_CTRL, 32'h0000_0005);
    wr(ldx_pkg::ADDR_CTRL, 32'h0);
    `CHK(LINK_ERROR_INTERRUPT, 1'b0)
    rd(ldx_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(ldx_pkg::ADDR_CTRL, 32'h0000_0006);
    `CHK(LINK_ERROR_INTERRUPT, 1'b0)
    rd(ldx_pkg::ADDR_CTRL, 32'h0000_0004);
    wr(ldx_pkg::ADDR_IRQ_MASK, 32'h1);
    `CHK(IRQ, 1'b1)
    rd(ldx_pkg::ADDR_IRQ_STATUS, 32'h1);
    `CHK(IRQ, 1'b0)
    rd(ldx_pkg::ADDR_IRQ_STATUS, 32'h0);
    acc(3'h0, 1'b1, 1'b1);
    wr(ldx_pkg::ADDR_IRQ_MASK, 32'h0);
    `CHK(IRQ, 1'b0)
    wr(ldx_pkg::ADDR_CTRL, 32'h0000_0006);
    XMEM_PAGE_MAPPING <= 8'hFF;
    $display("t_err done");
  endtask
  task automatic t_mux();
    logic [31:0] wt [3];
    logic [31:0] bs;
    wt = '{32'h0, 32'hFFFF_FFFF, 32'h2A95_803F};
    for (int k = 0; k < 3; k++) begin
      wr(ldx_pkg::ADDR_WORD_SEL, wt[k]);
      rd(ldx_pkg::ADDR_WORD_SEL, wt[k] & ldx_pkg::WORD_SEL_RW_MASK);
      for (int j = 0; j < 16; j++) begin
        bs = {8{j[3:0]}};
        wr(ldx_pkg::ADDR_BIT_SEL, bs);
        repeat (2) @(posedge CLK);
        `CHK(seen, port_exp(wt[k] & ldx_pkg::WORD_SEL_RW_MASK, bs))
      end
    end
    wr(ldx_pkg::ADDR_CTRL, 32'h0000_000C);
    repeat (2) @(posedge CLK);
    `CHK(seen, DIAG_OVR_DATA)
    wr(ldx_pkg::ADDR_CTRL, 32'h0000_0004);
    repeat (2) @(posedge CLK);
    `CHK(seen, port_exp(wt[2] & ldx_pkg::WORD_SEL_RW_MASK, bs))
    $display("t_mux done");
  endtask
  initial begin
    for (int g = 0; g < 64; g++) DIAG_GROUPS[8*g +: 8] = 8'(g * 37 + 11);
    repeat (10) @(posedge CLK);
    RESETN <= 1'b1;
    t_regs();
    t_base();
    t_err();
    t_mux();
    print_verdict();
  end
endmodule
